//--- hw/imb_pkg.sv
/*
 * Shared constants and types for the indexed memory-reference sequencer:
 * instruction field positions, slot codes, reset values, state and
 * operation enumerations.
 * Assumes a 16-bit word and four time slots per sequence state.
 */
package imb_pkg;

    localparam int WORD_W = 16;

    // Instruction field positions
    localparam int OFFSET_FIELD_LO   = 0;
    localparam int OFFSET_FIELD_W    = 5;
    localparam int RD_LO     = 5;
    localparam int RD_W      = 3;
    localparam int RX_LO     = 8;
    localparam int RX_W      = 2;
    localparam int IND_BIT   = 10;
    localparam int BASE_BIT  = 11;
    localparam int OP_LO     = 12;
    localparam int OP_W      = 4;

    // Displacement value that fetches the address from the next word
    localparam logic [OFFSET_FIELD_W-1:0] EXT_OFFSET_FIELD = 5'h1f;

    // Time slot codes
    localparam logic [1:0] SLOT1 = 2'h0;
    localparam logic [1:0] SLOT2 = 2'h1;
    localparam logic [1:0] SLOT3 = 2'h2;
    localparam logic [1:0] SLOT4 = 2'h3;

    // Values after reset
    localparam logic [WORD_W-1:0] PC_RST  = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [1:0]        SLOT_RST = 2'h3;

    typedef enum logic [1:0] {
        fetch_decode_state,
        extended_displacement_state,
        indirect_state,
        execute_state
    } imb_state_t;

    typedef enum logic [3:0] {
        op_none,
        load_register_op,
        op_store_reg,
        op_compare_reg,
        op_load_byte,
        op_store_byte,
        op_inc_mem,
        op_dec_mem,
        op_load_rs,
        op_store_rs,
        op_set_bit,
        op_test_bit,
        op_reset_bit
    } imb_op_t;

endpackage

//--- hw/imb_seq.sv
/*
 * Sequencer for the indexed memory-reference instruction group, carrying
 * the load-register instruction through address formation and execute.
 * One clock edge is one time slot. Memory sits outside: it sees the
 * location register on mem_addr, is started by memory_cycle_kick in slot four and
 * must present the addressed word on mem_rdata during the following
 * slot one, on this same clock.
 */
`timescale 1ns/1ps

// Contract
// - Fetch slot two copies destination register to both holders; PC gets PC+1+enable.
// - Later in fetch slot two, augend holder takes selected index register.
// - Instruction bit 10 set means indirect, clear means direct.
// - Fetch slot three loads base register into addend holder.
// - Indirect fetch slot three: address is displacement, upper bits zero.
// - Direct fetch slot three: address is displacement plus index when indexed.
// - Fetch slot four, displacement 1F: address and location from PC; go extended.
// - Otherwise address plus base into address and location; indirect or execute next.
// - Base added only when base-relative addressing is specified.
// - Extended slot two increments PC again, enable flag fed back through adder.
// - Extended slot three: indirect takes memory word, direct adds index.
// - Extended slot four: address plus base to address and location; branch.
// - Indirect slot three: address is memory word plus index when indexed.
// - Indirect slot four: address through adder to address and location; execute.
// - Execute slot one copies destination register to both holders.
// - Execute slot two of load writes memory data into destination register.
// - Execute slot four loads location from PC, returns to fetch.
// - Decode twelve group operations sharing indirect, index and displacement fields.
// - Memory word is captured into data register in slot one of each state.
// - Every slot four location load issues a memory start pulse.
module imb_seq #(
    parameter int NREG = 8
) (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic [imb_pkg::WORD_W-1:0] mem_rdata,
    input  wire logic [imb_pkg::WORD_W-1:0] base_value,
    input  wire logic                       con_wr,
    input  wire logic [2:0]                 con_sel,
    input  wire logic [imb_pkg::WORD_W-1:0] con_data,
    input  wire logic                       ise_load,
    input  wire logic                       ise_value,
    output logic      [imb_pkg::WORD_W-1:0] mem_addr,
    output logic                            memory_cycle_kick,
    output logic      [imb_pkg::WORD_W-1:0] pc,
    output logic      [imb_pkg::WORD_W-1:0] work_addr,
    output logic      [imb_pkg::WORD_W-1:0] data_word,
    output logic      [imb_pkg::WORD_W-1:0] con_rdata,
    output logic                            interrupt_enable_flag,
    output imb_pkg::imb_state_t             seq_state,
    output logic      [1:0]                 seq_slot,
    output imb_pkg::imb_op_t                op_kind,
    output logic                            indexed_memory_group
);

    localparam int WW = imb_pkg::WORD_W;

    imb_pkg::imb_state_t state_q;
    logic [1:0]          slot_q;
    logic [WW-1:0]       ir_q;
    logic [WW-1:0]       m_q;
    logic [WW-1:0]       p_q;
    logic [WW-1:0]       w_q;
    logic [WW-1:0]       l_q;
    logic [WW-1:0]       q_q;
    logic [WW-1:0]       r_q;
    logic                ise_q;
    logic [WW-1:0]       rf_q [NREG];

    logic [imb_pkg::OFFSET_FIELD_W-1:0] offset_field;
    logic [imb_pkg::RD_W-1:0]   rd_sel;
    logic [imb_pkg::RX_W-1:0]   rx_sel;
    logic                       ind;
    logic                       use_base;
    logic                       is_ext;
    logic [WW-1:0]              offset_field_word;
    logic [WW-1:0]              idx_add;
    logic [WW-1:0]              base_add;
    logic [WW-1:0]              pc_inc;
    logic [WW-1:0]              alu_sum;
    logic                       rf_wr;
    imb_pkg::imb_op_t           op_d;

    // Fields come from the held instruction; M is reused for data later
    assign offset_field = ir_q[imb_pkg::OFFSET_FIELD_LO +: imb_pkg::OFFSET_FIELD_W];
    assign rd_sel       = ir_q[imb_pkg::RD_LO +: imb_pkg::RD_W];
    assign rx_sel       = ir_q[imb_pkg::RX_LO +: imb_pkg::RX_W];
    assign ind          = ir_q[imb_pkg::IND_BIT];
    assign use_base     = ir_q[imb_pkg::BASE_BIT];
    assign is_ext       = (offset_field == imb_pkg::EXT_OFFSET_FIELD);
    assign offset_field_word    = {{(WW-imb_pkg::OFFSET_FIELD_W){1'b0}}, offset_field};

    // Index code zero means no indexing
    assign idx_add  = (rx_sel != '0) ? q_q : '0;
    assign base_add = use_base ? r_q : '0;
    assign pc_inc   = p_q + 16'h0001 + {{(WW-1){1'b0}}, ise_q};

    // Adder input selection per state and slot
    always_comb
    begin
        alu_sum = w_q;
        unique case (state_q)
            imb_pkg::fetch_decode_state:
            begin
                if (slot_q == imb_pkg::SLOT3)
                begin
                    alu_sum = ind ? offset_field_word : idx_add + offset_field_word;
                end
                else if (slot_q == imb_pkg::SLOT4)
                begin
                    alu_sum = is_ext ? p_q : w_q + base_add;
                end
            end
            imb_pkg::extended_displacement_state:
            begin
                if (slot_q == imb_pkg::SLOT3)
                begin
                    alu_sum = ind ? m_q : m_q + idx_add;
                end
                else if (slot_q == imb_pkg::SLOT4)
                begin
                    alu_sum = w_q + base_add;
                end
            end
            imb_pkg::indirect_state:
            begin
                if (slot_q == imb_pkg::SLOT3)
                begin
                    alu_sum = m_q + idx_add;
                end
            end
            imb_pkg::execute_state:
            begin
                alu_sum = p_q;
            end
        endcase
    end

    // Group decode on the held opcode
    always_comb
    begin
        op_d = imb_pkg::op_none;
        unique case (ir_q[imb_pkg::OP_LO +: imb_pkg::OP_W])
            4'hc: op_d = imb_pkg::load_register_op;
            4'hd: op_d = imb_pkg::op_store_reg;
            4'he: op_d = imb_pkg::op_compare_reg;
            4'h8: op_d = imb_pkg::op_load_byte;
            4'h9: op_d = imb_pkg::op_store_byte;
            4'hb: op_d = imb_pkg::op_set_bit;
            4'ha: op_d = imb_pkg::op_test_bit;
            4'h3: op_d = imb_pkg::op_reset_bit;
            4'hf:
            begin
                unique case (rd_sel)
                    3'h0:    op_d = imb_pkg::op_inc_mem;
                    3'h2:    op_d = imb_pkg::op_dec_mem;
                    3'h4:    op_d = imb_pkg::op_load_rs;
                    3'h6:    op_d = imb_pkg::op_store_rs;
                    default: op_d = imb_pkg::op_none;
                endcase
            end
            default: op_d = imb_pkg::op_none;
        endcase
    end

    // Slot counter and state; state changes only at the end of slot four
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // Start in execute slot four so the first edge fetches from PC
            slot_q  <= imb_pkg::SLOT_RST;
            state_q <= imb_pkg::execute_state;
        end
        else
        begin
            slot_q <= slot_q + 2'h1;
            if (slot_q == imb_pkg::SLOT4)
            begin
                unique case (state_q)
                    imb_pkg::fetch_decode_state:
                    begin
                        if (is_ext)
                        begin
                            state_q <= imb_pkg::extended_displacement_state;
                        end
                        else
                        begin
                            state_q <= ind ? imb_pkg::indirect_state
                                           : imb_pkg::execute_state;
                        end
                    end
                    imb_pkg::extended_displacement_state:
                    begin
                        state_q <= ind ? imb_pkg::indirect_state
                                       : imb_pkg::execute_state;
                    end
                    imb_pkg::indirect_state:
                    begin
                        state_q <= imb_pkg::execute_state;
                    end
                    imb_pkg::execute_state:
                    begin
                        state_q <= imb_pkg::fetch_decode_state;
                    end
                endcase
            end
        end
    end

    // Memory data capture at the end of every slot one
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            m_q  <= imb_pkg::WORD_RST;
            ir_q <= imb_pkg::WORD_RST;
        end
        else if (slot_q == imb_pkg::SLOT1)
        begin
            m_q <= mem_rdata;
            if (state_q == imb_pkg::fetch_decode_state)
            begin
                ir_q <= mem_rdata;
            end
        end
    end

    // Program counter and interrupt enable
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            p_q   <= imb_pkg::PC_RST;
            ise_q <= 1'b0;
        end
        else
        begin
            if (slot_q == imb_pkg::SLOT2 &&
                (state_q == imb_pkg::fetch_decode_state ||
                 state_q == imb_pkg::extended_displacement_state))
            begin
                p_q <= pc_inc;
            end
            // Flag passes the adder unchanged; only the console alters it
            if (ise_load)
            begin
                ise_q <= ise_value;
            end
        end
    end

    // Working address and memory location
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            w_q <= imb_pkg::WORD_RST;
            l_q <= imb_pkg::PC_RST;
        end
        else
        begin
            if (state_q != imb_pkg::execute_state &&
                (slot_q == imb_pkg::SLOT3 || slot_q == imb_pkg::SLOT4))
            begin
                w_q <= alu_sum;
            end
            if (slot_q == imb_pkg::SLOT4)
            begin
                l_q <= alu_sum;
            end
        end
    end

    // ALU holding registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q_q <= imb_pkg::WORD_RST;
            r_q <= imb_pkg::WORD_RST;
        end
        else
        begin
            if (state_q == imb_pkg::fetch_decode_state &&
                slot_q == imb_pkg::SLOT2)
            begin
                // Rd copy to Q is overwritten in the same slot by Rx
                q_q <= rf_q[{1'b0, rx_sel}];
                r_q <= rf_q[rd_sel];
            end
            else if (state_q == imb_pkg::fetch_decode_state &&
                     slot_q == imb_pkg::SLOT3)
            begin
                r_q <= base_value;
            end
            else if (state_q == imb_pkg::execute_state &&
                     slot_q == imb_pkg::SLOT1)
            begin
                q_q <= rf_q[rd_sel];
                r_q <= rf_q[rd_sel];
            end
        end
    end

    // Only the load operation writes the register file here
    assign rf_wr = (state_q == imb_pkg::execute_state) &&
                   (slot_q == imb_pkg::SLOT2) &&
                   (op_d == imb_pkg::load_register_op);

    // Register file; console write loses to an instruction write
    for (genvar i = 0; i < NREG; i++)
    begin : g_rf
        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                rf_q[i] <= imb_pkg::WORD_RST;
            end
            else if (rf_wr && int'(rd_sel) == i)
            begin
                rf_q[i] <= m_q;
            end
            else if (con_wr && int'(con_sel) == i)
            begin
                rf_q[i] <= con_data;
            end
        end
    end

    assign memory_cycle_kick     = (slot_q == imb_pkg::SLOT4);
    assign mem_addr              = l_q;
    assign pc                    = p_q;
    assign work_addr             = w_q;
    assign data_word             = m_q;
    assign con_rdata             = rf_q[con_sel];
    assign interrupt_enable_flag = ise_q;
    assign seq_state             = state_q;
    assign seq_slot              = slot_q;
    assign op_kind               = op_d;
    assign indexed_memory_group  = (op_d != imb_pkg::op_none);

endmodule

//--- sim/imb_seq_monitor.sv
/*
 * Port-level checker for imb_seq: slot pacing, memory kicks and the
 * address hand-offs between sequence states.
 * Assumes one clock and the active-low reset of imb_seq.
 */
`timescale 1ns/1ps
module imb_seq_monitor #(
    parameter int NREG = 8
) (
    input wire logic                clk,
    input wire logic                rst_b,
    input wire logic [15:0]         mem_rdata,
    input wire logic [15:0]         mem_addr,
    input wire logic                memory_cycle_kick,
    input wire logic [15:0]         pc,
    input wire logic [15:0]         work_addr,
    input wire logic [15:0]         data_word,
    input wire logic                interrupt_enable_flag,
    input imb_pkg::imb_state_t      seq_state,
    input wire logic [1:0]          seq_slot,
    input imb_pkg::imb_op_t         op_kind,
    input wire logic                indexed_memory_group
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    kick_slot_a: assert property (
        memory_cycle_kick == (seq_slot == 2'h3)) else $error("kick outside slot four");
    slot_step_a: assert property (
        rst_b |=> seq_slot == 2'($past(seq_slot) + 2'h1)) else $error("slot skipped");
    state_hold_a: assert property (
        seq_slot != 2'h3 |=> $stable(seq_state)) else $error("state moved early");
    addr_hold_a: assert property (
        !memory_cycle_kick |=> $stable(mem_addr)) else $error("location moved without kick");
    capture_a: assert property (
        seq_slot == 2'h0 |=> data_word == $past(mem_rdata)) else $error("word not captured");
    pc_step_a: assert property (
        seq_state == imb_pkg::fetch_decode_state && seq_slot == 2'h1 |=>
        pc == 16'($past(pc) + 16'h1 + 16'($past(interrupt_enable_flag))))
        else $error("pc step wrong");
    ind_start_a: assert property (
        seq_state == imb_pkg::fetch_decode_state && seq_slot == 2'h2 && data_word[10] |=>
        work_addr == {11'h000, data_word[4:0]}) else $error("indirect start address wrong");
    ext_entry_a: assert property (
        seq_state == imb_pkg::fetch_decode_state && seq_slot == 2'h3 && data_word[4:0] == 5'h1f
        |=> seq_state == imb_pkg::extended_displacement_state && mem_addr == $past(pc)
        && work_addr == $past(pc)) else $error("extended entry wrong");
    fetch_exit_a: assert property (
        seq_state == imb_pkg::fetch_decode_state && seq_slot == 2'h3 && data_word[4:0] != 5'h1f
        |=> mem_addr == work_addr && seq_state == (data_word[10] ? imb_pkg::indirect_state
        : imb_pkg::execute_state)) else $error("fetch exit wrong");
    ind_exit_a: assert property (
        seq_state == imb_pkg::indirect_state && seq_slot == 2'h3 |=>
        seq_state == imb_pkg::execute_state && mem_addr == $past(work_addr))
        else $error("indirect exit wrong");
    exec_exit_a: assert property (
        seq_state == imb_pkg::execute_state && seq_slot == 2'h3 |=>
        seq_state == imb_pkg::fetch_decode_state && mem_addr == $past(pc))
        else $error("execute exit wrong");
    group_flag_a: assert property (
        indexed_memory_group == (op_kind != imb_pkg::op_none)) else $error("group flag wrong");
    load_decode_a: assert property (
        seq_state == imb_pkg::fetch_decode_state && seq_slot != 2'h0 |->
        (op_kind == imb_pkg::load_register_op) == (data_word[15:12] == 4'hc))
        else $error("load decode wrong");
    ext_step_a: assert property (
        seq_state == imb_pkg::extended_displacement_state && seq_slot == 2'h1 |=>
        pc == 16'($past(pc) + 16'h1 + 16'($past(interrupt_enable_flag))))
        else $error("extended pc step wrong");
endmodule

bind imb_seq imb_seq_monitor #(.NREG(NREG)) imb_seq_monitor_i (
    .clk(clk), .rst_b(rst_b), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .memory_cycle_kick(memory_cycle_kick), .pc(pc), .work_addr(work_addr),
    .data_word(data_word), .interrupt_enable_flag(interrupt_enable_flag),
    .seq_state(seq_state), .seq_slot(seq_slot), .op_kind(op_kind),
    .indexed_memory_group(indexed_memory_group)
);

//--- sim/imb_mem_model.sv
/*
 * Behavioural core memory behind the location register.
 * Assumes the word is wanted only in the slot after a kick.
 */
`timescale 1ns/1ps
module imb_mem_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] mem_addr,
    input  wire logic        memory_cycle_kick,
    output logic      [15:0] mem_rdata
);
    logic [15:0] mem [0:255];
    logic        live_q;
    logic [15:0] last_q;

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            live_q <= 1'b0;
        else
            live_q <= memory_cycle_kick;

    always_ff @(posedge clk)
        last_q <= mem_rdata;

    // Outside the read slot the bus toggles, so stale data never looks valid
    assign mem_rdata = live_q ? mem[mem_addr[7:0]] : ~last_q;
endmodule

//--- sim/imb_seq_tb_top.sv
/*
 * Self-checking bench for imb_seq running random group instructions.
 * Assumes imb_mem_model as memory and the bound port checker.
 */
`timescale 1ns/1ps
module imb_seq_tb_top;
    logic             clk, rst_b, con_wr, ise_load, ise_value, kick, flag, grp;
    logic [15:0]      rdata, base, cdata, addr, pc, wa, dw, crd, e_pc, e_ea, e_val, ins, v;
    logic [2:0]       csel, e_rd;
    logic [1:0]       slot;
    logic             e_flag;
    logic [3:0]       opc;
    logic [15:0]      sh [0:7];
    imb_pkg::imb_state_t st;
    imb_pkg::imb_op_t    opk, e_op;
    int               mismatches, check_count;
    // One test per non-load group code, sub-operations and an unused code included
    localparam logic [3:0] OPS [12] = '{4'hd, 4'he, 4'h8, 4'h9, 4'hb, 4'ha, 4'h3,
                                        4'hf, 4'hf, 4'hf, 4'hf, 4'h0};

    imb_mem_model mem_i (.clk(clk), .rst_b(rst_b), .mem_addr(addr),
        .memory_cycle_kick(kick), .mem_rdata(rdata));
    imb_seq imb_seq_i (.clk(clk), .rst_b(rst_b), .mem_rdata(rdata), .base_value(base),
        .con_wr(con_wr), .con_sel(csel), .con_data(cdata), .ise_load(ise_load),
        .ise_value(ise_value), .mem_addr(addr), .memory_cycle_kick(kick), .pc(pc),
        .work_addr(wa), .data_word(dw), .con_rdata(crd), .interrupt_enable_flag(flag),
        .seq_state(st), .seq_slot(slot), .op_kind(opk), .indexed_memory_group(grp));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Group operation named by the opcode table
    function automatic imb_pkg::imb_op_t exp_op(input logic [15:0] w);
        case (w[15:12])
            4'hc: return imb_pkg::load_register_op;
            4'hd: return imb_pkg::op_store_reg;
            4'he: return imb_pkg::op_compare_reg;
            4'h8: return imb_pkg::op_load_byte;
            4'h9: return imb_pkg::op_store_byte;
            4'hb: return imb_pkg::op_set_bit;
            4'ha: return imb_pkg::op_test_bit;
            4'h3: return imb_pkg::op_reset_bit;
            4'hf:
                case (w[7:5])
                    3'h0:    return imb_pkg::op_inc_mem;
                    3'h2:    return imb_pkg::op_dec_mem;
                    3'h4:    return imb_pkg::op_load_rs;
                    3'h6:    return imb_pkg::op_store_rs;
                    default: return imb_pkg::op_none;
                endcase
            default: return imb_pkg::op_none;
        endcase
    endfunction

    // Walks the address path the way the sequencer should
    task automatic predict();
        logic [15:0] q, p1, w;
        q = ins[9:8] != 2'h0 ? sh[{1'b0, ins[9:8]}] : 16'h0000;
        p1 = e_pc + 16'h0001 + 16'(e_flag);
        if (ins[4:0] == 5'h1f)
        begin
            w = mem_i.mem[p1[7:0]];
            e_pc = p1 + 16'h0001 + 16'(e_flag);
            w = ins[10] ? w : w + q;
        end
        else
        begin
            e_pc = p1;
            w = ins[10] ? 16'(ins[4:0]) : 16'(ins[4:0]) + q;
        end
        w = ins[11] ? w + base : w;
        if (ins[10])
            w = mem_i.mem[w[7:0]] + q;
        e_ea = w;
        e_rd = ins[7:5];
        e_val = ins[15:12] == 4'hc ? mem_i.mem[w[7:0]] : sh[e_rd];
        e_op = exp_op(ins);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        #(100 * 60 * 40);
        mismatches++;
        close_out();
    end

    initial
    begin
        rst_b = 1'b0;
        con_wr = 1'b0;
        cdata = 16'h0000;
        ise_load = 1'b0;
        ise_value = 1'b0;
        mismatches = 0;
        check_count = 0;
        void'($urandom(4));
        base = 16'($urandom);
        for (int i = 0; i < 256; i++)
            mem_i.mem[i] = 16'($urandom);
        for (int i = 0; i < 8; i++)
            sh[i] = 16'h0000;
        e_pc = 16'h0000;
        e_flag = 1'b0;
        ins = {4'hc, 12'($urandom)};
        mem_i.mem[0] = ins;
        csel = ins[7:5];
        predict();
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        for (int t = 0; t < 60; t++)
        begin
            do @(negedge clk); while (!(st == imb_pkg::execute_state && slot == 2'h2));
            sh[e_rd] = e_val;
            check("register", crd, e_val);
            check("location", addr, e_ea);
            check("work address", wa, e_ea);
            check("counter", pc, e_pc);
            check("operation", 16'(opk), 16'(e_op));
            check("group", 16'(grp), 16'(e_op != imb_pkg::op_none));
            check("enable flag", 16'(flag), 16'(e_flag));
            check("data word", dw, mem_i.mem[e_ea[7:0]]);
            $display("test %0d done", t);
            opc = (t >= 8 && t < 20) ? OPS[t - 8] : 4'hc;
            ins = {opc, 12'($urandom)};
            // Memory-word group picks its sub-operation from the register field
            if (opc == 4'hf)
                ins[7:5] = 3'(2 * (t - 15));
            // Corner table: extended word, indirect and base in every mix
            if (t < 8)
            begin
                ins[4:0] = t[0] ? 5'h1f : ins[4:0];
                ins[10] = t[1];
                ins[11] = t[2];
            end
            v = 16'($urandom);
            e_flag = 1'($urandom);
            @(posedge clk);
            con_wr <= 1'b1;
            csel <= ins[7:5];
            cdata <= v;
            ise_load <= 1'b1;
            ise_value <= e_flag;
            base <= 16'($urandom);
            sh[ins[7:5]] = v;
            v = 16'($urandom);
            @(posedge clk);
            csel <= {1'b0, ins[9:8]};
            cdata <= v;
            ise_load <= 1'b0;
            sh[{1'b0, ins[9:8]}] = v;
            mem_i.mem[e_pc[7:0]] = ins;
            predict();
            @(posedge clk);
            con_wr <= 1'b0;
            csel <= ins[7:5];
        end
        close_out();
    end
endmodule
